// ---- design/brt_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "brt_regs.svh"
module brt_top #(
    parameter int CLK_HZ = `BRT_CLK_HZ,
    parameter int REC_MS = `BRT_REC_MS,
    parameter int REC_CYC = CLK_HZ / 1000 * REC_MS,
    parameter int SEC_CYC = CLK_HZ
) (
    input wire logic clk,                  // system clock
    input wire logic reset,                // async reset, active high
    input wire logic chip_select_n,        // chip select, active low
    input wire logic output_enable_n,      // output enable, active low
    input wire logic write_strobe_n,       // write strobe, active low
    input wire logic [14:0] address_lines, // byte address
    input wire logic [7:0] data_lines_in,  // data bus in
    output logic [7:0] data_lines_out,     // data bus out
    output logic data_lines_oe,            // data bus drive enable
    input wire logic power_fail            // supply below threshold
);
    // ****************************************************
    // elaboration checks
    // ****************************************************
    if (REC_MS < `BRT_REC_MIN_MS || REC_MS > `BRT_REC_MAX_MS)
        $error("recovery delay out of range");
    if (REC_CYC < 1 || SEC_CYC < 2)
        $error("counts too small");

    // ****************************************************
    // power-fail deselect and recovery
    // ****************************************************
    brt_pkg::brt_pwr_t pwr_q;
    logic [31:0] rec_cnt_q;
    logic bus_ok;

    // deselect on fail, hold off for recovery delay after
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pwr_q <= brt_pkg::PWR_FAIL;
            rec_cnt_q <= '0;
        end else if (power_fail) begin
            pwr_q <= brt_pkg::PWR_FAIL;
            rec_cnt_q <= '0;
        end else begin
            case (pwr_q)
                brt_pkg::PWR_FAIL: begin
                    pwr_q <= brt_pkg::PWR_RECOVER;
                    rec_cnt_q <= '0;
                end
                brt_pkg::PWR_RECOVER: begin
                    if (rec_cnt_q >= 32'(REC_CYC - 1)) begin
                        pwr_q <= brt_pkg::PWR_OK;
                    end
                    rec_cnt_q <= rec_cnt_q + 32'd1;
                end
                brt_pkg::PWR_OK: pwr_q <= brt_pkg::PWR_OK;
                default: pwr_q <= brt_pkg::PWR_FAIL;
            endcase
        end
    end
    assign bus_ok = (pwr_q == brt_pkg::PWR_OK) && !power_fail;

    // ****************************************************
    // write cycle detection
    // ****************************************************
    logic wr_act;
    logic wr_q;
    logic [14:0] wr_addr_q;
    logic [7:0] wr_data_q;
    logic wr_end;

    // cycle spans overlap of select and strobe low
    assign wr_act = bus_ok && !chip_select_n && !write_strobe_n;

    // track data while active; commit at the end of the overlap
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wr_q <= 1'b0;
            wr_addr_q <= '0;
            wr_data_q <= '0;
        end else begin
            wr_q <= wr_act;
            if (wr_act) begin
                wr_addr_q <= address_lines;
                wr_data_q <= data_lines_in;
            end
        end
    end
    // a cut by power fail still commits only the addressed byte
    assign wr_end = wr_q && !wr_act;

    logic is_clk_reg;
    assign is_clk_reg = wr_addr_q >= `BRT_ADR_CTRL;

    // ****************************************************
    // clock control and timekeeping registers
    // ****************************************************
    logic [7:0] ctrl_q;
    brt_pkg::brt_time_t regs_q;
    brt_pkg::brt_time_t now;
    logic halt;
    logic xfer;
    logic [31:0] div_q;
    logic tick;
    logic osc_run_q;
    logic [31:0] start_q;

    assign halt = ctrl_q[`BRT_CTRL_READ_BIT] ||
                  ctrl_q[`BRT_CTRL_WRITE_BIT];
    assign xfer = wr_end && wr_addr_q == `BRT_ADR_CTRL &&
                  ctrl_q[`BRT_CTRL_WRITE_BIT] &&
                  !wr_data_q[`BRT_CTRL_WRITE_BIT];

    // control byte; calibration kept in d5..d0
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ctrl_q <= `BRT_CTRL_RESET;
        end else if (wr_end && wr_addr_q == `BRT_ADR_CTRL) begin
            ctrl_q <= wr_data_q;
        end
    end

    // oscillator start delay after stop bit clears
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            osc_run_q <= 1'b0;
            start_q <= '0;
        end else if (regs_q.sec[`BRT_SEC_STOP_BIT]) begin
            osc_run_q <= 1'b0;
            start_q <= '0;
        end else if (!osc_run_q) begin
            start_q <= start_q + 32'd1;
            if (start_q >= 32'(SEC_CYC / 2)) begin
                osc_run_q <= 1'b1;
            end
        end
    end

    // one second divider, restarted by a transfer
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            div_q <= '0;
        end else if (xfer || !osc_run_q) begin
            div_q <= '0;
        end else if (div_q >= 32'(SEC_CYC - 1)) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 32'd1;
        end
    end
    assign tick = osc_run_q && !xfer && div_q >= 32'(SEC_CYC - 1);

    brt_counter brt_counter_inst (
        .clk(clk),
        .reset(reset),
        .tick(tick),
        .load(xfer),
        .load_val(regs_q),
        .now_q(now)
    );

    // register bytes: host writes, else copy each tick when not halted, stop and ft bits kept
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            regs_q <= '0;
            regs_q.sec <= `BRT_SEC_RESET;
        end else if (wr_end && is_clk_reg && wr_addr_q != `BRT_ADR_CTRL) begin
            case (wr_addr_q)
                `BRT_ADR_SEC: regs_q.sec <= wr_data_q;
                `BRT_ADR_MIN: regs_q.min <= wr_data_q;
                `BRT_ADR_HOUR: regs_q.hour <= wr_data_q;
                `BRT_ADR_WDAY: regs_q.wday <= wr_data_q;
                `BRT_ADR_DATE: regs_q.date <= wr_data_q;
                `BRT_ADR_MON: regs_q.month <= wr_data_q;
                default: regs_q.year <= wr_data_q;
            endcase
        end else if (tick && !halt) begin
            regs_q <= now;
            regs_q.sec[`BRT_SEC_STOP_BIT] <= regs_q.sec[`BRT_SEC_STOP_BIT];
            regs_q.wday[`BRT_WDAY_FT_BIT] <= regs_q.wday[`BRT_WDAY_FT_BIT];
        end
    end

    // ****************************************************
    // memory array and read path
    // ****************************************************
    logic [7:0] mem_rd;
    logic [7:0] reg_rd_q;
    logic rd_reg_q;

    brt_mem #(
        .AW(15)
    ) brt_mem_inst (
        .clk(clk),
        .we(wr_end && !is_clk_reg),
        .waddr(wr_addr_q),
        .wdata(wr_data_q),
        .raddr(address_lines),
        .rdata(mem_rd)
    );

    // registered clock byte read
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            reg_rd_q <= '0;
            rd_reg_q <= 1'b0;
        end else begin
            rd_reg_q <= address_lines >= `BRT_ADR_CTRL;
            case (address_lines)
                `BRT_ADR_CTRL: reg_rd_q <= ctrl_q;
                `BRT_ADR_SEC: reg_rd_q <= regs_q.sec;
                `BRT_ADR_MIN: reg_rd_q <= regs_q.min;
                `BRT_ADR_HOUR: reg_rd_q <= regs_q.hour;
                `BRT_ADR_WDAY: reg_rd_q <= regs_q.wday;
                `BRT_ADR_DATE: reg_rd_q <= regs_q.date;
                `BRT_ADR_MON: reg_rd_q <= regs_q.month;
                default: reg_rd_q <= regs_q.year;
            endcase
        end
    end

    // drive only in a valid read; strobe low floats the bus
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            data_lines_oe <= 1'b0;
            data_lines_out <= '0;
        end else begin
            data_lines_oe <= bus_ok && !chip_select_n &&
                             !output_enable_n && write_strobe_n;
            data_lines_out <= rd_reg_q ? reg_rd_q : mem_rd;
        end
    end

    // ****************************************************
    // assertions
    // ****************************************************
    logic [31:0] ok_run_q;

    // cycles since the supply last came back, for the recovery check
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ok_run_q <= '0;
        end else if (power_fail) begin
            ok_run_q <= '0;
        end else if (ok_run_q != 32'hffffffff) begin
            ok_run_q <= ok_run_q + 32'd1;
        end
    end

    property p_fail_float;
        @(posedge clk) disable iff (reset)
        power_fail |=> !data_lines_oe;
    endproperty
    a_fail_float: assert property (p_fail_float)
        else $error("bus driven during power fail");

    property p_no_write_fail;
        @(posedge clk) disable iff (reset)
        power_fail |-> !wr_act;
    endproperty
    a_no_write_fail: assert property (p_no_write_fail)
        else $error("write taken during power fail");

    property p_recover_hold;
        @(posedge clk) disable iff (reset)
        $fell(power_fail) |-> !bus_ok [*8];
    endproperty
    a_recover_hold: assert property (p_recover_hold)
        else $error("access before recovery delay");

    property p_recover_len;
        @(posedge clk) disable iff (reset)
        bus_ok |-> ok_run_q > 32'(REC_CYC);
    endproperty
    a_recover_len: assert property (p_recover_len)
        else $error("access resumed before recovery delay");

    property p_strobe_float;
        @(posedge clk) disable iff (reset)
        !write_strobe_n |=> !data_lines_oe;
    endproperty
    a_strobe_float: assert property (p_strobe_float)
        else $error("bus driven with write strobe low");

    // one overlap cycle on the control byte, then the overlap ends
    sequence s_ctrl_write;
        (wr_act && address_lines == `BRT_ADR_CTRL) ##1 !wr_act;
    endsequence

    property p_ctrl_write;
        @(posedge clk) disable iff (reset)
        s_ctrl_write |=> ctrl_q == $past(wr_data_q);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write)
        else $error("control byte not taken at end of write");

    property p_halt_hold;
        @(posedge clk) disable iff (reset)
        (halt && !wr_end && $past(halt)) |=> $stable(regs_q.min);
    endproperty
    a_halt_hold: assert property (p_halt_hold)
        else $error("registers changed while halted");

    property p_tick_copy;
        @(posedge clk) disable iff (reset)
        (tick && !halt && !wr_end) |=> regs_q.min == $past(now.min);
    endproperty
    a_tick_copy: assert property (p_tick_copy)
        else $error("registers not refreshed on tick");

    property p_xfer_load;
        @(posedge clk) disable iff (reset)
        xfer |=> now.hour == $past(regs_q.hour);
    endproperty
    a_xfer_load: assert property (p_xfer_load)
        else $error("counters not loaded on transfer");

    property p_stop_hold;
        @(posedge clk) disable iff (reset)
        regs_q.sec[`BRT_SEC_STOP_BIT] |=> !tick;
    endproperty
    a_stop_hold: assert property (p_stop_hold)
        else $error("tick while oscillator stopped");

    property p_mem_only;
        @(posedge clk) disable iff (reset)
        (wr_end && !is_clk_reg) |=> $stable(regs_q.hour) || $past(tick);
    endproperty
    a_mem_only: assert property (p_mem_only)
        else $error("plain memory write touched clock");
endmodule
`default_nettype wire

// ---- design/brt_regs.svh ----
`ifndef BRT_REGS_SVH
`define BRT_REGS_SVH
// ****************************************************
// register map
// ****************************************************
`define BRT_ADDR_W 15
`define BRT_ADR_CTRL 15'h7ff8
`define BRT_ADR_SEC 15'h7ff9
`define BRT_ADR_MIN 15'h7ffa
`define BRT_ADR_HOUR 15'h7ffb
`define BRT_ADR_WDAY 15'h7ffc
`define BRT_ADR_DATE 15'h7ffd
`define BRT_ADR_MON 15'h7ffe
`define BRT_ADR_YEAR 15'h7fff
// ****************************************************
// field positions
// ****************************************************
`define BRT_CTRL_WRITE_BIT 7
`define BRT_CTRL_READ_BIT 6
`define BRT_CTRL_SIGN_BIT 5
`define BRT_SEC_STOP_BIT 7
`define BRT_WDAY_FT_BIT 6
// ****************************************************
// reset values and timing
// ****************************************************
`define BRT_SEC_RESET 8'h80
`define BRT_CTRL_RESET 8'h00
`define BRT_REC_MIN_MS 40
`define BRT_REC_MAX_MS 200
`define BRT_REC_MS 100
`define BRT_CLK_HZ 50000000
`define BRT_OSC_START_S 1
`endif

// ---- design/brt_pkg.sv ----
`default_nettype none
package brt_pkg;
    // time of day in bcd, one byte per field
    typedef struct packed {
        logic [7:0] year;
        logic [7:0] month;
        logic [7:0] date;
        logic [7:0] wday;
        logic [7:0] hour;
        logic [7:0] min;
        logic [7:0] sec;
    } brt_time_t;
    // power state of the bus side
    typedef enum logic [1:0] {
        PWR_FAIL,
        PWR_RECOVER,
        PWR_OK
    } brt_pwr_t;
endpackage
`default_nettype wire

// ---- design/brt_mem.sv ----
`timescale 1ns/1ps
`default_nettype none
// byte memory with registered read data
module brt_mem #(
    parameter int AW = 15
) (
    input wire logic clk,            // system clock
    input wire logic we,             // write strobe
    input wire logic [AW-1:0] waddr, // write address
    input wire logic [7:0] wdata,    // write data
    input wire logic [AW-1:0] raddr, // read address
    output logic [7:0] rdata         // registered read data
);
    logic [7:0] mem [0:(1<<AW)-1];

    // one write port, one registered read port
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule
`default_nettype wire

// ---- design/brt_counter.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "brt_regs.svh"
// true timekeeping counters in bcd, one step per tick
module brt_counter (
    input wire logic clk,                    // system clock
    input wire logic reset,                  // async reset
    input wire logic tick,                   // one second pulse
    input wire logic load,                   // load new time
    input wire brt_pkg::brt_time_t load_val, // time to load
    output brt_pkg::brt_time_t now_q         // running time
);
    // bcd increment with wrap to lo at hi
    function automatic logic [7:0] bcd_inc(input logic [7:0] v,
                                           input logic [7:0] hi,
                                           input logic [7:0] lo);
        logic [7:0] r;
        r = v;
        if (v >= hi) begin
            r = lo;
        end else if (v[3:0] >= 4'h9) begin
            r = {v[7:4] + 4'h1, 4'h0};
        end else begin
            r = {v[7:4], v[3:0] + 4'h1};
        end
        return r;
    endfunction

    // last day of month, leap by two-digit year
    function automatic logic [7:0] month_end(input logic [7:0] m,
                                             input logic [7:0] y);
        logic [7:0] r;
        logic leap;
        leap = (y[4] == 1'b0) ? (y[1:0] == 2'b00) : (y[1:0] == 2'b10);
        case (m)
            8'h02: r = leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: r = 8'h30;
            default: r = 8'h31;
        endcase
        return r;
    endfunction

    brt_pkg::brt_time_t nx;

    // cascade of rollovers; control bits kept as they are
    always_comb begin
        nx = now_q;
        nx.sec[6:0] = 7'(bcd_inc({1'b0, now_q.sec[6:0]}, 8'h59, 8'h00));
        if (now_q.sec[6:0] == 7'h59) begin
            nx.min[6:0] = 7'(bcd_inc({1'b0, now_q.min[6:0]}, 8'h59, 8'h00));
            if (now_q.min[6:0] == 7'h59) begin
                nx.hour = bcd_inc(now_q.hour, 8'h23, 8'h00);
                if (now_q.hour == 8'h23) begin
                    nx.wday[2:0] = (now_q.wday[2:0] >= 3'd7) ? 3'd1 :
                                   now_q.wday[2:0] + 3'd1;
                    nx.date = bcd_inc(now_q.date,
                                      month_end(now_q.month, now_q.year),
                                      8'h01);
                    if (now_q.date >= month_end(now_q.month, now_q.year)) begin
                        nx.month = bcd_inc(now_q.month, 8'h12, 8'h01);
                        if (now_q.month >= 8'h12) begin
                            nx.year = bcd_inc(now_q.year, 8'h99, 8'h00);
                        end
                    end
                end
            end
        end
    end

    // counters advance on tick, load wins
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            now_q <= '0;
        end else if (load) begin
            now_q <= load_val;
        end else if (tick) begin
            now_q <= nx;
        end
    end
endmodule
`default_nettype wire

// ---- dv/brt_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************************
// host bus model
// ****************************************************
module brt_host_model (
    input wire logic clk,                  // system clock
    output logic chip_select_n,            // select, active low
    output logic output_enable_n,          // output enable, active low
    output logic write_strobe_n,           // write strobe, active low
    output logic [14:0] address_lines,     // byte address
    output logic [7:0] data_lines_in,      // data toward device
    input wire logic [7:0] data_lines_out, // device read data
    input wire logic data_lines_oe         // device drives bus
);
    // idle bus, select held high from time zero
    initial begin
        chip_select_n = 1'b1;
        output_enable_n = 1'b1;
        write_strobe_n = 1'b1;
        address_lines = 15'h0000;
        data_lines_in = 8'h00;
    end

    // one write cycle; sel low keeps select high
    task automatic wr(input logic [14:0] a, input logic [7:0] d,
                      input bit sel = 1'b1);
        @(posedge clk);
        #1;
        output_enable_n = 1'b1;
        address_lines = a;
        data_lines_in = d;
        chip_select_n = !sel;
        write_strobe_n = 1'b0;
        @(posedge clk);
        #1;
        write_strobe_n = 1'b1;
        chip_select_n = 1'b1;
        data_lines_in = ~d;     // released bus shows no stale byte
        @(posedge clk);
    endtask

    // one read cycle, data taken two edges on
    task automatic rd(input logic [14:0] a, output logic [7:0] d,
                      output logic oe);
        @(posedge clk);
        #1;
        address_lines = a;
        chip_select_n = 1'b0;
        output_enable_n = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        d = data_lines_out;
        oe = data_lines_oe;
        chip_select_n = 1'b1;
        output_enable_n = 1'b1;
    endtask
endmodule
`default_nettype wire

// ---- dv/tb_battery_backed_sram_rtc_bus.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "brt_regs.svh"
module tb_battery_backed_sram_rtc_bus;
    localparam int SEC = 50;
    localparam int REC = 20;
    logic clk, reset, power_fail, cs_n, oe_n, we_n, doe, oe;
    logic [14:0] addr;
    logic [7:0] din, dout, d;
    int failures = 0;
    int samples_checked = 0;
    int k, k2;
    logic [14:0] ra [6];
    logic [7:0] rv [6];
    brt_pkg::brt_time_t t0, t1, t2;

    // ****************************************************
    // device and host
    // ****************************************************
    brt_top #(.REC_CYC(REC), .SEC_CYC(SEC)) brt_top_inst (
        .clk(clk), .reset(reset), .chip_select_n(cs_n),
        .output_enable_n(oe_n), .write_strobe_n(we_n),
        .address_lines(addr), .data_lines_in(din),
        .data_lines_out(dout), .data_lines_oe(doe),
        .power_fail(power_fail)
    );
    brt_host_model brt_host_model_inst (
        .clk(clk), .chip_select_n(cs_n), .output_enable_n(oe_n),
        .write_strobe_n(we_n), .address_lines(addr),
        .data_lines_in(din), .data_lines_out(dout),
        .data_lines_oe(doe)
    );

    // free running clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // bcd increment with wrap
    function automatic logic [7:0] nx(logic [7:0] v, logic [7:0] hi,
                                      logic [7:0] lo);
        if (v == hi) return lo;
        if (v[3:0] == 4'h9) return {v[7:4] + 4'h1, 4'h0};
        return v + 8'h01;
    endfunction

    // advance by n seconds, months of 31 days only
    function automatic brt_pkg::brt_time_t adv(brt_pkg::brt_time_t t,
                                               int n);
        for (int i = 0; i < n; i++) begin
            t.sec = nx(t.sec, 8'h59, 8'h00);
            if (t.sec != 8'h00) continue;
            t.min = nx(t.min, 8'h59, 8'h00);
            if (t.min != 8'h00) continue;
            t.hour = nx(t.hour, 8'h23, 8'h00);
            if (t.hour != 8'h00) continue;
            t.wday = nx(t.wday, 8'h07, 8'h01);
            t.date = nx(t.date, 8'h31, 8'h01);
            if (t.date != 8'h01) continue;
            t.month = nx(t.month, 8'h12, 8'h01);
            if (t.month == 8'h01) t.year = nx(t.year, 8'h99, 8'h00);
        end
        return t;
    endfunction

    // ****************************************************
    // checking helpers
    // ****************************************************
    task automatic chk(input string n, input logic [7:0] seen,
                       input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic w(input logic [14:0] a, input logic [7:0] v,
                     input bit sel = 1'b1);
        brt_host_model_inst.wr(a, v, sel);
    endtask

    // read with drive enable and data compared
    task automatic rdc(input string n, input logic [14:0] a,
                       input logic [7:0] exp);
        brt_host_model_inst.rd(a, d, oe);
        chk({n, "_oe"}, {7'h0, oe}, 8'h01);
        chk(n, d, exp);
    endtask

    // all seven time fields compared
    task automatic cmp_t(input string n, input brt_pkg::brt_time_t s,
                         input brt_pkg::brt_time_t e);
        for (int i = 0; i < 7; i++) chk(n, s[8*i +: 8], e[8*i +: 8]);
    endtask

    // freeze registers, read time, seconds elapsed from t0
    task automatic snap(output brt_pkg::brt_time_t t, output int n);
        w(`BRT_ADR_CTRL, 8'h40);
        for (int i = 0; i < 7; i++) begin
            brt_host_model_inst.rd(`BRT_ADR_SEC + 15'(i), d, oe);
            t[8*i +: 8] = d;
        end
        n = (10 * t.sec[6:4] + t.sec[3:0] + 2) % 60;
    endtask

    // ****************************************************
    // main sequence
    // ****************************************************
    initial begin
        void'($urandom(32'h788c));
        power_fail = 1'b0;
        reset = 1'b1;
        repeat (8) @(posedge clk);
        #1;
        reset = 1'b0;
        w(15'h0100, 8'ha5);
        brt_host_model_inst.rd(15'h0100, d, oe);
        chk("rec_oe", {7'h0, oe}, 8'h00);
        repeat (REC + 5) @(posedge clk);
        brt_host_model_inst.rd(15'h0100, d, oe);
        chk("rec_blk", {7'h0, d !== 8'ha5}, 8'h01);
        rdc("ctrl_rst", `BRT_ADR_CTRL, 8'h00);
        brt_host_model_inst.rd(`BRT_ADR_SEC, d, oe);
        chk("stop_rst", d & 8'h80, 8'h80);
        w(`BRT_ADR_CTRL, 8'h25);
        rdc("calib", `BRT_ADR_CTRL, 8'h25);
        w(`BRT_ADR_CTRL, 8'h00);
        // random plain bytes, lowest and highest plain address
        for (int i = 0; i < 6; i++) begin
            ra[i] = (i == 0) ? 15'h0000 : (i == 5) ? 15'h7ff7 :
                    15'(i * 4096 + $urandom % 4096);
            rv[i] = 8'($urandom);
            w(ra[i], rv[i]);
        end
        w(ra[1], ~rv[1], 1'b0);
        for (int i = 0; i < 6; i++) rdc("ram", ra[i], rv[i]);
        // load a time just before the year wraps
        t0 = {8'h99, 8'h12, 8'h31, 8'h07, 8'h23, 8'h59, 8'h58};
        w(`BRT_ADR_CTRL, 8'h80);
        for (int i = 0; i < 7; i++) w(`BRT_ADR_SEC + 15'(i), t0[8*i +: 8]);
        w(`BRT_ADR_CTRL, 8'h00);
        repeat (5 * SEC) @(posedge clk);
        snap(t1, k);
        chk("gap", {7'h0, k >= 3 && k <= 7}, 8'h01);
        cmp_t("t1", t1, adv(t0, k));
        repeat (3 * SEC) @(posedge clk);
        snap(t2, k2);
        cmp_t("hold", t2, t1);
        w(`BRT_ADR_CTRL, 8'h00);
        repeat (SEC + 10) @(posedge clk);
        snap(t2, k2);
        chk("gap2", {7'h0, k2 >= k + 4 && k2 <= k + 7}, 8'h01);
        cmp_t("t2", t2, adv(t0, k2));
        // stopped oscillator keeps the seconds
        w(`BRT_ADR_CTRL, 8'h80);
        w(`BRT_ADR_SEC, 8'hb0);
        w(`BRT_ADR_CTRL, 8'h00);
        repeat (3 * SEC) @(posedge clk);
        w(`BRT_ADR_CTRL, 8'h40);
        rdc("stopped", `BRT_ADR_SEC, 8'hb0);
        // power fail blocks access, keeps contents
        w(15'h0200, 8'h11);
        #1;
        power_fail = 1'b1;
        w(15'h0200, 8'h22);
        brt_host_model_inst.rd(15'h0200, d, oe);
        chk("pf_oe", {7'h0, oe}, 8'h00);
        power_fail = 1'b0;
        brt_host_model_inst.rd(15'h0200, d, oe);
        chk("rc_oe", {7'h0, oe}, 8'h00);
        repeat (REC + 5) @(posedge clk);
        rdc("pf_keep", 15'h0200, 8'h11);
        for (int i = 0; i < 6; i++) rdc("pf_ram", ra[i], rv[i]);
        results();
    end

    // hang guard
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        results();
    end
endmodule
`default_nettype wire
